// [shared/lpb_pkg.sv]
// Constants, types and register map of the low-power supply-drop reset block
// ---------------------------------------------------------------------------
// How it works
// (R1) Enabled detector reporting supply below trip level holds device reset asserted.
// (R2) A low-power brown-out reset sets the brown-out flag for software to read.
// (R3) Both detectors share one brown-out flag; no indication of which one tripped.
// (R4) Configuration should enable the detector when brown-out field is 00 or 10; code turns the ordinary detector on for 01, 11 and awake 10, off for 00.
// (R5) Detector enable comes from a nonvolatile configuration bit, not a run-time register.
// (R6) Erased configuration bit means the low-power detector is disabled.
// (R7) After brown-out or power-on release, optional power-up timer delays execution.
// (R8) Execution starts only after power-up timer ends and master clear releases.
// (R9) Reset request drops once supply rises above trip; normal start-up follows.
// ---------------------------------------------------------------------------
package lpb_pkg;

    // -----------------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------------
    localparam int unsigned LPB_CLK_MHZ = 100;
    localparam int unsigned LPB_PWRUP_TIME_US = 64;      // Plain default, no figure given
    localparam int unsigned LPB_EXEC_START_CYCLES = 10;  // Oscillator cycles after release
    localparam int unsigned LPB_CNT_W = 32;

    // -----------------------------------------------------------------------
    // Configuration word encodings
    // -----------------------------------------------------------------------
    localparam logic LPB_CFG_ERASED = 1'h1;              // Erased nonvolatile bit value
    localparam logic [1:0] LPB_BROWNOUT_ENABLE_FIELD_OFF = 2'h0;
    localparam logic [1:0] LPB_BROWNOUT_ENABLE_FIELD_SW = 2'h1;
    localparam logic [1:0] LPB_BROWNOUT_ENABLE_FIELD_NOSLEEP = 2'h2;
    localparam logic [1:0] LPB_BROWNOUT_ENABLE_FIELD_ON = 2'h3;

    // -----------------------------------------------------------------------
    // Register map, byte addresses on the bus
    // -----------------------------------------------------------------------
    localparam int unsigned LPB_ADR_W = 8;
    localparam logic [7:0] LPB_OFF_STATUS = 8'h00;       // Sticky events, write one to clear
    localparam logic [7:0] LPB_OFF_MASK = 8'h04;         // Interrupt enables
    localparam logic [7:0] LPB_OFF_INFO = 8'h08;         // Latched config and sequencer state

    // Status and mask bit positions
    localparam int unsigned LPB_EVT_W = 3;
    localparam int unsigned LPB_BIT_BROWNOUT = 0;        // Shared brown-out reset flag
    localparam int unsigned LPB_BIT_PWRUP = 1;           // Power-up timer expired
    localparam int unsigned LPB_BIT_EXTERNAL_MASTER_CLEAR_N = 2;            // Master-clear reset seen

    // Info register field positions
    localparam int unsigned LPB_INFO_STATE_LSB = 0;
    localparam int unsigned LPB_INFO_DROP_EN = 6;
    localparam int unsigned LPB_INFO_PWRT_EN = 7;
    localparam int unsigned LPB_INFO_EXTERNAL_MASTER_CLEAR_N_EN = 8;
    localparam int unsigned LPB_INFO_BROWNOUT_ENABLE_FIELD_LSB = 9;
    localparam int unsigned LPB_INFO_SUPPLY_LOW = 11;

    // Synchroniser lanes
    localparam int unsigned LPB_SYN_W = 3;
    localparam int unsigned LPB_SYN_SUPPLY_LOW = 0;
    localparam int unsigned LPB_SYN_STD_LOW = 1;
    localparam int unsigned LPB_SYN_EXTERNAL_MASTER_CLEAR_N_N = 2;
    localparam logic [2:0] LPB_SYN_RST = 3'h4;           // Master clear idles high

    // -----------------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------------
    typedef enum logic [5:0] {
        LPB_ST_LOAD = 6'h01,
        LPB_ST_HOLD = 6'h02,
        LPB_ST_PWRUP = 6'h04,
        LPB_ST_EXTERNAL_MASTER_CLEAR_N = 6'h08,
        LPB_ST_START = 6'h10,
        LPB_ST_RUN = 6'h20
    } lpb_state_t;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } lpb_sync_t;

    typedef struct packed {
        lpb_state_t state;
        logic cfg_drop_en;
        logic cfg_pwrt_en;
        logic cfg_external_master_clear_n_en;
        logic [1:0] cfg_brownout_enable_field;
        logic [LPB_CNT_W-1:0] cnt;
        logic [LPB_EVT_W-1:0] status;
        logic [LPB_EVT_W-1:0] mask;
        logic [31:0] rdata;
        logic ack;
        logic irq;
        logic core_rst_n;
    } lpb_regs_t;

    localparam lpb_regs_t LPB_REGS_RST = '{
        state: LPB_ST_LOAD,
        cfg_drop_en: 1'h0,
        cfg_pwrt_en: 1'h0,
        cfg_external_master_clear_n_en: 1'h0,
        cfg_brownout_enable_field: 2'h0,
        cnt: 32'h0000_0000,
        status: 3'h0,
        mask: 3'h0,
        rdata: 32'h0000_0000,
        ack: 1'h0,
        irq: 1'h0,
        core_rst_n: 1'h0
    };

endpackage : lpb_pkg

// [src/lpb_brownout.sv]
// Low-power supply-drop reset sequencer with Wishbone status registers
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps

module lpb_brownout #(
    parameter int unsigned PWRUP_CYCLES = lpb_pkg::LPB_PWRUP_TIME_US * lpb_pkg::LPB_CLK_MHZ
) (
    input wire logic clk_i,                              // 100 MHz clock
    input wire logic rstn_i,                             // Power-on reset, sync, active low
    // Configuration words, stable nonvolatile straps
    input wire logic cfg_drop_detect_bit_i,              // 0 enables detector, erased 1
    input wire logic [1:0] brownout_enable_field_i,      // Ordinary detector mode
    input wire logic powerup_timer_enable_n_i,           // Power-up timer, active low
    input wire logic cfg_external_master_clear_n_enable_i,                  // Master-clear pin in use
    // Analogue and pin levels, asynchronous; sleep flag on the same clock
    input wire logic supply_below_low_power_trip_i,      // Low-power comparator trip
    input wire logic supply_below_standard_trip_i,       // Ordinary comparator trip
    input wire logic external_master_clear_n_i,          // Master-clear pin, active low
    input wire logic sleep_i,                            // Core in sleep, same clock
    // Wishbone classic slave
    input wire logic wb_cyc_i,                           // Bus cycle
    input wire logic wb_stb_i,                           // Strobe
    input wire logic wb_we_i,                            // Write enable
    input wire logic [lpb_pkg::LPB_ADR_W-1:0] wb_adr_i,  // Byte address
    input wire logic [3:0] wb_sel_i,                     // Byte lanes
    input wire logic [31:0] wb_dat_i,                    // Write data
    output logic [31:0] wb_dat_o,                        // Read data
    output logic wb_ack_o,                               // Acknowledge
    // Results
    output logic core_reset_n_o,                         // Device reset, active low
    output logic irq_o                                   // Level interrupt
);

    lpb_pkg::lpb_regs_t r;
    lpb_pkg::lpb_regs_t r_next;
    logic [lpb_pkg::LPB_SYN_W-1:0] syn;
    logic supply_low;
    logic std_low;
    logic external_master_clear_n_n;
    logic std_en;
    logic drop_trip;
    logic std_trip;
    logic bo_trip;
    logic bus_req;
    logic bus_wr;
    logic [lpb_pkg::LPB_EVT_W-1:0] evt;
    logic [lpb_pkg::LPB_EVT_W-1:0] clr;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------------
    lpb_sync u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i({external_master_clear_n_i, supply_below_standard_trip_i,
                  supply_below_low_power_trip_i}),
        .sync_o(syn)
    );

    assign supply_low = syn[lpb_pkg::LPB_SYN_SUPPLY_LOW];
    assign std_low = syn[lpb_pkg::LPB_SYN_STD_LOW];
    assign external_master_clear_n_n = syn[lpb_pkg::LPB_SYN_EXTERNAL_MASTER_CLEAR_N_N];

    // ------------------------------------------------------------------------
    // Trip decode
    // ------------------------------------------------------------------------
    // Ordinary detector: on, software mode treated as on, or on unless asleep
    always_comb begin
        unique case (r.cfg_brownout_enable_field)
            lpb_pkg::LPB_BROWNOUT_ENABLE_FIELD_OFF: std_en = 1'h0;
            lpb_pkg::LPB_BROWNOUT_ENABLE_FIELD_SW: std_en = 1'h1;
            lpb_pkg::LPB_BROWNOUT_ENABLE_FIELD_NOSLEEP: std_en = !sleep_i;
            lpb_pkg::LPB_BROWNOUT_ENABLE_FIELD_ON: std_en = 1'h1;
        endcase
    end

    // Latched config bit gates the low-power detector, never a bus write
    assign drop_trip = r.cfg_drop_en && supply_low; // R1 R5
    assign std_trip = std_en && std_low;
    assign bo_trip = drop_trip || std_trip; // R3

    // Bus strobes: writes land on the same edge that sees ack high
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_wr = bus_req && wb_we_i && r.ack && wb_sel_i[0];

    // Read mux, unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            lpb_pkg::LPB_OFF_STATUS: rd_mux[lpb_pkg::LPB_EVT_W-1:0] = r.status;
            lpb_pkg::LPB_OFF_MASK: rd_mux[lpb_pkg::LPB_EVT_W-1:0] = r.mask;
            lpb_pkg::LPB_OFF_INFO: begin
                rd_mux[lpb_pkg::LPB_INFO_STATE_LSB +: 6] = r.state;
                rd_mux[lpb_pkg::LPB_INFO_DROP_EN] = r.cfg_drop_en;
                rd_mux[lpb_pkg::LPB_INFO_PWRT_EN] = r.cfg_pwrt_en;
                rd_mux[lpb_pkg::LPB_INFO_EXTERNAL_MASTER_CLEAR_N_EN] = r.cfg_external_master_clear_n_en;
                rd_mux[lpb_pkg::LPB_INFO_BROWNOUT_ENABLE_FIELD_LSB +: 2] = r.cfg_brownout_enable_field;
                rd_mux[lpb_pkg::LPB_INFO_SUPPLY_LOW] = supply_low;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer, status and bus next state
    // ------------------------------------------------------------------------
    always_comb begin
        r_next = r;
        evt = '0;
        clr = '0;
        // Classic single cycle: ack one cycle after the strobe, then drop
        r_next.ack = bus_req && !r.ack;
        if (bus_req && !r.ack) begin
            r_next.rdata = rd_mux;
        end

        unique case (r.state)
            lpb_pkg::LPB_ST_LOAD: begin
                // Straps caught once after power-on release, erased means off
                r_next.cfg_drop_en = (cfg_drop_detect_bit_i != lpb_pkg::LPB_CFG_ERASED); // R5 R6
                r_next.cfg_pwrt_en = !powerup_timer_enable_n_i;
                r_next.cfg_external_master_clear_n_en = cfg_external_master_clear_n_enable_i;
                r_next.cfg_brownout_enable_field = brownout_enable_field_i;
                r_next.cnt = '0;
                r_next.state = lpb_pkg::LPB_ST_PWRUP;
            end
            lpb_pkg::LPB_ST_HOLD: begin
                // Supply back above trip: leave reset through normal start-up
                if (!bo_trip) begin
                    r_next.state = lpb_pkg::LPB_ST_PWRUP; // R9
                    r_next.cnt = '0;
                end
            end
            lpb_pkg::LPB_ST_PWRUP: begin
                // Timer runs regardless of the master-clear pin
                if (!r.cfg_pwrt_en) begin
                    r_next.state = lpb_pkg::LPB_ST_EXTERNAL_MASTER_CLEAR_N; // R7
                end else if (r.cnt == lpb_pkg::LPB_CNT_W'(PWRUP_CYCLES - 1)) begin
                    r_next.state = lpb_pkg::LPB_ST_EXTERNAL_MASTER_CLEAR_N; // R7
                    evt[lpb_pkg::LPB_BIT_PWRUP] = 1'h1;
                end else begin
                    r_next.cnt = r.cnt + 1'b1;
                end
            end
            lpb_pkg::LPB_ST_EXTERNAL_MASTER_CLEAR_N: begin
                // Wait for pin release when the pin is enabled
                if (!r.cfg_external_master_clear_n_en || external_master_clear_n_n) begin
                    r_next.state = lpb_pkg::LPB_ST_START; // R8
                    r_next.cnt = '0;
                end
            end
            lpb_pkg::LPB_ST_START: begin
                // Short fixed delay before the core is let go
                if (r.cnt == lpb_pkg::LPB_CNT_W'(lpb_pkg::LPB_EXEC_START_CYCLES - 1)) begin
                    r_next.state = lpb_pkg::LPB_ST_RUN;
                end else begin
                    r_next.cnt = r.cnt + 1'b1;
                end
            end
            lpb_pkg::LPB_ST_RUN: begin
                if (r.cfg_external_master_clear_n_en && !external_master_clear_n_n) begin
                    r_next.state = lpb_pkg::LPB_ST_EXTERNAL_MASTER_CLEAR_N;
                    evt[lpb_pkg::LPB_BIT_EXTERNAL_MASTER_CLEAR_N] = 1'h1;
                end
            end
            default: r_next.state = lpb_pkg::LPB_ST_LOAD;
        endcase

        // A trip overrides every state but the strap load
        if (bo_trip && r.state != lpb_pkg::LPB_ST_LOAD) begin
            r_next.state = lpb_pkg::LPB_ST_HOLD; // R1
            if (r.state != lpb_pkg::LPB_ST_HOLD) begin
                evt[lpb_pkg::LPB_BIT_BROWNOUT] = 1'h1; // R2 R3
            end
        end

        // Register writes; a new event wins over a clear in the same cycle
        if (bus_wr && wb_adr_i == lpb_pkg::LPB_OFF_STATUS) begin
            clr = wb_dat_i[lpb_pkg::LPB_EVT_W-1:0];
        end
        if (bus_wr && wb_adr_i == lpb_pkg::LPB_OFF_MASK) begin
            r_next.mask = wb_dat_i[lpb_pkg::LPB_EVT_W-1:0];
        end
        r_next.status = (r.status & ~clr) | evt; // R2
        r_next.irq = |(r_next.status & r_next.mask);
        // Reset output follows the registered state, so it is glitch free
        r_next.core_rst_n = (r_next.state == lpb_pkg::LPB_ST_RUN); // R1 R8
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            r <= lpb_pkg::LPB_REGS_RST;
        end else begin
            r <= r_next;
        end
    end

    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign core_reset_n_o = r.core_rst_n;
    assign irq_o = r.irq;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Trip outside strap load forces reset in the next cycle
    AST_HOLD_ON_TRIP: assert property ( // R1
        drop_trip && r.state != lpb_pkg::LPB_ST_LOAD |=> !core_reset_n_o
            && r.state == lpb_pkg::LPB_ST_HOLD)
        else $error("reset not held during low-power trip");

    // Reset stays low for as long as the trip persists
    AST_HOLD_STAYS: assert property ( // R1
        r.state == lpb_pkg::LPB_ST_HOLD && bo_trip |=> !core_reset_n_o [*2])
        else $error("reset released while supply low");

    // Entering hold from running sets the flag
    AST_FLAG_SET: assert property ( // R2
        drop_trip && r.state == lpb_pkg::LPB_ST_RUN |=> r.status[lpb_pkg::LPB_BIT_BROWNOUT])
        else $error("brown-out flag not set");

    // Ordinary detector lands in the very same flag
    AST_SHARED_FLAG: assert property ( // R3
        std_trip && !drop_trip && r.state == lpb_pkg::LPB_ST_RUN
            |=> r.status[lpb_pkg::LPB_BIT_BROWNOUT] && r.status[lpb_pkg::LPB_BIT_EXTERNAL_MASTER_CLEAR_N]
            == $past(r.status[lpb_pkg::LPB_BIT_EXTERNAL_MASTER_CLEAR_N]))
        else $error("ordinary trip did not use shared flag");

    // Latched enable never moves after strap load
    AST_CFG_FROZEN: assert property ( // R5
        r.state != lpb_pkg::LPB_ST_LOAD |=> $stable(r.cfg_drop_en))
        else $error("detector enable changed at run time");

    // Erased strap leaves the detector off
    AST_ERASED_OFF: assert property ( // R6
        r.state == lpb_pkg::LPB_ST_LOAD && cfg_drop_detect_bit_i == lpb_pkg::LPB_CFG_ERASED
            |=> !r.cfg_drop_en)
        else $error("erased configuration enabled detector");

    // Timer must not end early
    AST_PWRUP_FULL: assert property ( // R7
        r.state == lpb_pkg::LPB_ST_PWRUP && r.cfg_pwrt_en
            && r.cnt != lpb_pkg::LPB_CNT_W'(PWRUP_CYCLES - 1)
            |=> r.state inside {lpb_pkg::LPB_ST_PWRUP, lpb_pkg::LPB_ST_HOLD})
        else $error("power-up timer ended early");

    // Held master clear blocks start
    AST_EXTERNAL_MASTER_CLEAR_N_BLOCKS: assert property ( // R8
        r.state == lpb_pkg::LPB_ST_EXTERNAL_MASTER_CLEAR_N && r.cfg_external_master_clear_n_en && !external_master_clear_n_n
            |=> r.state != lpb_pkg::LPB_ST_START)
        else $error("start while master clear low");

    // Start delay keeps the core in reset
    AST_START_DELAY: assert property ( // R8
        $rose(r.state == lpb_pkg::LPB_ST_START) |-> !core_reset_n_o [*8])
        else $error("core released before start delay");

    // Supply recovery restarts the normal sequence
    AST_RELEASE: assert property ( // R9
        r.state == lpb_pkg::LPB_ST_HOLD && !bo_trip |=> r.state == lpb_pkg::LPB_ST_PWRUP)
        else $error("hold not left after supply recovery");

    COV_LOW_POWER_HOLD: cover property (
        drop_trip && r.state == lpb_pkg::LPB_ST_RUN ##1 r.state == lpb_pkg::LPB_ST_HOLD);
    COV_REACH_RUN: cover property ($rose(core_reset_n_o));
    COV_EXTERNAL_MASTER_CLEAR_N_RESET: cover property (
        r.state == lpb_pkg::LPB_ST_RUN ##1 r.state == lpb_pkg::LPB_ST_EXTERNAL_MASTER_CLEAR_N);
    COV_IRQ: cover property ($rose(irq_o));

endmodule : lpb_brownout

// [src/lpb_sync.sv]
// Two-stage synchroniser for the asynchronous comparator and pin inputs
`timescale 1ns/100ps

module lpb_sync (
    input wire logic clk_i,                              // System clock
    input wire logic rstn_i,                             // Synchronous reset, active low
    input wire logic [lpb_pkg::LPB_SYN_W-1:0] async_i,   // Raw asynchronous levels
    output logic [lpb_pkg::LPB_SYN_W-1:0] sync_o         // Levels safe for clk_i logic
);

    lpb_pkg::lpb_sync_t r;
    lpb_pkg::lpb_sync_t r_next;

    // ------------------------------------------------------------------------
    // Per-lane next value; first stage feeds only the second
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < lpb_pkg::LPB_SYN_W; i++) begin : g_lane
        always_comb begin
            r_next.meta[i] = async_i[i];
            r_next.stable[i] = r.meta[i];
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            r <= '{meta: lpb_pkg::LPB_SYN_RST, stable: lpb_pkg::LPB_SYN_RST};
        end else begin
            r <= r_next;
        end
    end

    assign sync_o = r.stable;

endmodule : lpb_sync

// [tb/lpb_brownout_bench.sv]
// Self-checking bench for the low-power supply-drop reset block
`timescale 1ns/100ps

module lpb_brownout_bench;
    localparam int unsigned PWRUP = 20; // Short power-up timer keeps the run brief
    logic clk_i = 1'b0, rstn_i = 1'b0, cfg_bit = 1'b0, pwrt_n = 1'b0, external_master_clear_n_en = 1'b1;
    logic [1:0] brownout_enable_field = 2'h0;
    logic sleep = 1'b0, low_cmd = 1'b0, std_cmd = 1'b0, pin_low = 1'b0, slow = 1'b0;
    logic low_trip, std_trip, external_master_clear_n_n, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, core_rst_n, irq;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat;
    int num_errors = 0, compares = 0, cycles = 0;

    lpb_supply_model model (.clk_i(clk_i), .low_cmd_i(low_cmd), .std_cmd_i(std_cmd),
        .pin_low_i(pin_low), .slow_i(slow), .low_trip_o(low_trip), .std_trip_o(std_trip),
        .external_master_clear_n_n_o(external_master_clear_n_n));
    lpb_brownout #(.PWRUP_CYCLES(PWRUP)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
        .cfg_drop_detect_bit_i(cfg_bit), .brownout_enable_field_i(brownout_enable_field),
        .powerup_timer_enable_n_i(pwrt_n), .cfg_external_master_clear_n_enable_i(external_master_clear_n_en),
        .supply_below_low_power_trip_i(low_trip), .supply_below_standard_trip_i(std_trip),
        .external_master_clear_n_i(external_master_clear_n_n), .sleep_i(sleep), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .core_reset_n_o(core_rst_n), .irq_o(irq));

    // Clock and run watchdog; a hang is cut short well past the longest test
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One classic cycle; request held until ack is sampled high
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) check("bus ack", 32'h1, 32'h0);
    endtask : wb_cycle

    task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask : wb_write

    task automatic wb_read(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        check(name, exp, q);
    endtask : wb_read

    // Edges until the device reset reaches lvl, judged against a window
    task automatic span(input string name, input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (core_rst_n !== lvl && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        compares++;
        if (n < lo || n > hi) begin
            num_errors++;
            $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, n);
        end
    endtask : span

    // Device reset must sit at lvl on every edge of the stretch
    task automatic hold(input string name, input logic lvl, input int len);
        logic seen;
        seen = lvl;
        repeat (len) begin
            @(posedge clk_i);
            if (core_rst_n !== lvl) seen = core_rst_n;
        end
        check(name, {31'h0, lvl}, {31'h0, seen});
    endtask : hold

    task automatic power_on(input logic c, input logic [1:0] b, input logic p, input logic m);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        cfg_bit <= c;
        brownout_enable_field <= b;
        pwrt_n <= p;
        external_master_clear_n_en <= m;
        repeat (6) @(posedge clk_i);
        check("reset outputs", 32'h0, {29'h0, core_rst_n, irq, ack});
        rstn_i <= 1'b1;
    endtask : power_on

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_power_up();
        power_on(1'b0, 2'h0, 1'b0, 1'b1);
        span("release with timer", 1'b1, PWRUP + 10, PWRUP + 16);
        wb_read("mask reset", 8'h04, 32'h0);
        wb_read("unmapped", 8'h0C, 32'h0);
        wb_read("info", 8'h08, 32'h1E0);
        wb_read("status timer", 8'h00, 32'h2);
        wb_write(8'h00, 32'h7);
        wb_read("status cleared", 8'h00, 32'h0);
    endtask : t_power_up

    task automatic t_drop();
        wb_write(8'h04, 32'h1);
        cfg_bit <= 1'b1;
        low_cmd <= 1'b1;
        span("trip to reset", 1'b0, 1, 4);
        hold("reset held", 1'b0, 60);
        check("irq on drop", 32'h1, {31'h0, irq});
        wb_read("status drop", 8'h00, 32'h1);
        wb_write(8'h00, 32'h1);
        // The clear lands on the ack edge; irq is registered on it, so look one edge on
        @(posedge clk_i);
        check("irq cleared", 32'h0, {31'h0, irq});
        slow <= 1'b1;
        low_cmd <= 1'b0;
        span("release after drop", 1'b1, PWRUP + 10, PWRUP + 22);
        wb_write(8'h00, 32'h7);
        slow <= 1'b0;
        cfg_bit <= 1'b0;
    endtask : t_drop

    task automatic t_external_master_clear_n();
        pin_low <= 1'b1;
        span("pin to reset", 1'b0, 1, 5);
        hold("pin held", 1'b0, 40);
        pin_low <= 1'b0;
        span("pin release", 1'b1, 10, 18);
        wb_read("status pin", 8'h00, 32'h4);
        check("masked irq", 32'h0, {31'h0, irq});
        wb_write(8'h00, 32'h7);
    endtask : t_external_master_clear_n

    // Every ordinary mode while asleep and awake, erased low-power detector
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            power_on(1'b1, m[1:0], 1'b1, 1'b0);
            span("release no timer", 1'b1, 10, 18);
            wb_write(8'h00, 32'h7);
            sleep <= 1'b1;
            low_cmd <= 1'b1;
            std_cmd <= 1'b1;
            // Two synchroniser edges plus the hold entry edge pass before reset falls
            repeat (4) @(posedge clk_i);
            hold("asleep", (m == 0 || m == 2), 12);
            sleep <= 1'b0;
            // Sleep is same-clock; the trip shows on the output one edge later
            repeat (2) @(posedge clk_i);
            hold("awake", (m == 0), 12);
            wb_read("shared flag", 8'h00, {31'h0, m != 0});
            low_cmd <= 1'b0;
            std_cmd <= 1'b0;
            sleep <= 1'b0;
        end
    endtask : t_modes

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        t_power_up();
        t_drop();
        t_external_master_clear_n();
        t_modes();
        print_verdict();
    end
endmodule : lpb_brownout_bench

// [tb/lpb_supply_model.sv]
// Behavioural comparators and master-clear pin facing the supply-drop reset block
`timescale 1ns/100ps

module lpb_supply_model (
    input wire logic clk_i,      // System clock
    input wire logic low_cmd_i,  // Supply commanded below the low-power trip
    input wire logic std_cmd_i,  // Supply commanded below the standard trip
    input wire logic pin_low_i,  // Master-clear button pressed
    input wire logic slow_i,     // Comparators answer four cycles late
    output logic low_trip_o,     // Low-power comparator output
    output logic std_trip_o,     // Standard comparator output
    output logic external_master_clear_n_n_o        // Master-clear pin level
);
    logic [3:0] low_dly = 4'h0;
    logic [3:0] std_dly = 4'h0;

    // Settling delay line; a slow comparator lags the real supply
    always @(posedge clk_i) begin
        low_dly <= {low_dly[2:0], low_cmd_i};
        std_dly <= {std_dly[2:0], std_cmd_i};
    end

    // Comparator outputs, prompt or lagging
    assign low_trip_o = slow_i ? low_dly[3] : low_cmd_i;
    assign std_trip_o = slow_i ? std_dly[3] : std_cmd_i;
    // Weak pull-up holds the pin high once the button lets go
    assign external_master_clear_n_n_o = ~pin_low_i;
endmodule : lpb_supply_model
